/* File: hw/vdsr_pkg.sv */
// Package: register map, field layout, reset values and counts for the decoder status/format registers
package vdsr_pkg;
  localparam logic [7:0] OFS_DEVICE_CONDITION = 8'h00;
  localparam logic [7:0] OFS_INPUT_SOURCE_FORMAT = 8'h01;
  localparam logic [7:0] OFS_TEMPORAL_DROP_CONTROL = 8'h02;
  localparam logic [7:0] OFS_WINDOW_UPPER_BITS = 8'h03;
  localparam logic [7:0] OFS_VERTICAL_DELAY_LOW = 8'h04;

  localparam logic [7:0] RST_DEVICE_CONDITION = 8'h00;
  localparam logic [7:0] RST_INPUT_SOURCE_FORMAT = 8'h58;
  localparam logic [7:0] RST_TEMPORAL_DROP_CONTROL = 8'h00;
  localparam logic [7:0] RST_WINDOW_UPPER_BITS = 8'h12;
  localparam logic [7:0] RST_VERTICAL_DELAY_LOW = 8'h16;

  // Status bit positions
  localparam int BIT_PRESENT = 7;
  localparam int BIT_HLOCK = 6;
  localparam int BIT_FIELD = 5;
  localparam int BIT_LINES = 4;
  localparam int BIT_XTAL = 3;
  localparam int BIT_RSVD = 2;
  localparam int BIT_LUMA_OVF = 1;
  localparam int BIT_CHROMA_OVF = 0;
  // Input format fields
  localparam int BIT_EXTEND = 7;
  localparam int POS_MUX = 5;
  localparam int POS_XTAL = 3;
  localparam int POS_STD = 0;
  // Temporal drop fields
  localparam int BIT_DEC_UNIT = 7;

  localparam logic [1:0] MUX_IN2 = 2'b01;
  localparam logic [1:0] MUX_IN0 = 2'b10;
  localparam logic [1:0] MUX_IN1 = 2'b11;
  localparam logic [1:0] XT_PORT0 = 2'b01;
  localparam logic [1:0] XT_PORT1 = 2'b10;
  localparam logic [1:0] XT_AUTO = 2'b11;
  localparam logic [1:0] STD_AUTO = 2'b00;
  localparam logic [1:0] STD_NTSC = 2'b01;
  localparam logic [1:0] STD_PAL = 2'b11;

  localparam logic [4:0] PRESENT_CYCLES = 5'd31;
  localparam logic [5:0] LOCK_LINES = 6'd32;
  localparam logic [5:0] STD_FIELDS = 6'd32;
  localparam logic [9:0] LINES_625_MIN = 10'd288;
  localparam logic [6:0] UNITS_NTSC = 7'd60;
  localparam logic [6:0] UNITS_PAL = 7'd50;

  typedef struct packed {
    logic above_half_sync;
    logic line_strobe;
    logic hsync_match;
    logic field_end;
    logic [9:0] lines_in_field;
    logic luma_ovf;
    logic chroma_ovf;
    logic luma_sleep;
    logic chroma_sleep;
  } vdsr_vid_t;

  typedef struct packed {
    logic [2:0] mux_onehot;
    logic crystal_port;
    logic standard_pal;
    logic extend_active;
    logic [6:0] drop_count;
    logic decimate_fields;
    logic [9:0] vertical_delay_count;
    logic [1:0] vertical_active_msb;
    logic [1:0] horizontal_delay_msb;
    logic [1:0] horizontal_active_msb;
  } vdsr_cfg_t;
endpackage

/* File: hw/vdsr_regs.sv */
// Status, input format, decimation and cropping registers of the video decoder
`timescale 1ns/1ns
`default_nettype none
module vdsr_regs (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire vdsr_pkg::vdsr_vid_t vid_in,
  input wire logic horizontal_reset_out_b_in,
  input wire logic vertical_reset_out_b_in,
  output vdsr_pkg::vdsr_cfg_t cfg_out,
  output logic drop_unit_out
);
  import vdsr_pkg::*;

  logic [7:0] format_r;
  logic [7:0] temporal_drop_control_r;
  logic [7:0] window_upper_bits_r;
  logic [7:0] vdly_lo_r;
  logic [7:0] rdata_r;
  logic present_r;
  logic hlock_r;
  logic field_even_r;
  logic lines_pal_r;
  logic luma_ovf_r;
  logic chroma_ovf_r;
  logic [4:0] above_cnt_r;
  logic [5:0] match_cnt_r;
  logic [5:0] miss_cnt_r;
  logic [5:0] std_cnt_r;
  logic vertical_reset_out_b_d_r;
  logic [6:0] acc_r;
  logic drop_r;

  // Register select shared by every write strobe
  function automatic logic at_ofs(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Address decode
  wire wr_status = reg_wr_in && at_ofs(reg_addr_in, OFS_DEVICE_CONDITION);
  wire wr_format = reg_wr_in && at_ofs(reg_addr_in, OFS_INPUT_SOURCE_FORMAT);
  wire wr_temporal_drop_control = reg_wr_in && at_ofs(reg_addr_in, OFS_TEMPORAL_DROP_CONTROL);
  wire wr_window_upper_bits = reg_wr_in && at_ofs(reg_addr_in, OFS_WINDOW_UPPER_BITS);
  wire wr_vdly = reg_wr_in && at_ofs(reg_addr_in, OFS_VERTICAL_DELAY_LOW);

  // Video present detection
  wire present_set = (above_cnt_r == PRESENT_CYCLES);
  wire present_clr = wr_status && !reg_wdata_in[BIT_PRESENT];
  wire [4:0] above_cnt_nxt = !vid_in.above_half_sync ? 5'd0 :
                             present_set ? above_cnt_r : above_cnt_r + 5'd1;

  // Horizontal lock: line counters saturate at the lock length
  wire line_hit = vid_in.line_strobe && vid_in.hsync_match;
  wire line_miss = vid_in.line_strobe && !vid_in.hsync_match;
  wire [5:0] match_cnt_nxt = line_miss ? 6'd0 :
                             (line_hit && match_cnt_r != LOCK_LINES) ? match_cnt_r + 6'd1 : match_cnt_r;
  wire [5:0] miss_cnt_nxt = line_hit ? 6'd0 :
                            (line_miss && miss_cnt_r != LOCK_LINES) ? miss_cnt_r + 6'd1 : miss_cnt_r;
  wire hlock_nxt = (match_cnt_nxt == LOCK_LINES) ? 1'b1 :
                   (miss_cnt_nxt == LOCK_LINES) ? 1'b0 : hlock_r;

  // Field parity: a vertical reset starting mid-line marks an even field
  wire vertical_reset_out_start = vertical_reset_out_b_d_r && !vertical_reset_out_b_in;
  wire field_even_nxt = vertical_reset_out_start ? horizontal_reset_out_b_in : field_even_r;

  // Line standard: a new class must persist for 32 fields before it shows
  wire field_pal = (vid_in.lines_in_field >= LINES_625_MIN);
  wire std_differs = vid_in.field_end && (field_pal != lines_pal_r);
  wire std_agrees = vid_in.field_end && (field_pal == lines_pal_r);
  wire [5:0] std_cnt_nxt = std_agrees ? 6'd0 : std_differs ? std_cnt_r + 6'd1 : std_cnt_r;
  wire std_flip = std_differs && (std_cnt_r == STD_FIELDS - 6'd1);

  // Overflow flags: event beats a clearing write
  wire luma_ovf_nxt = vid_in.luma_ovf ? 1'b1 : wr_status ? 1'b0 : luma_ovf_r;
  wire chroma_ovf_nxt = vid_in.chroma_ovf ? 1'b1 : wr_status ? 1'b0 : chroma_ovf_r;
  wire luma_ovf_rd = luma_ovf_r || vid_in.luma_sleep;
  wire chroma_ovf_rd = chroma_ovf_r || vid_in.chroma_sleep;

  // Format decode
  wire [1:0] mux_sel = format_r[POS_MUX +: 2];
  wire [1:0] xt_sel = format_r[POS_XTAL +: 2];
  wire [1:0] std_sel = format_r[POS_STD +: 2];
  wire crystal_sel = (xt_sel == XT_AUTO) ? lines_pal_r : (xt_sel == XT_PORT1);
  wire std_pal = (std_sel == STD_AUTO) ? lines_pal_r : (std_sel == STD_PAL);

  wire [7:0] status_rd = {present_r, hlock_r, field_even_r, lines_pal_r,
                          crystal_sel, 1'b0, luma_ovf_rd, chroma_ovf_rd};

  // Decimation: spread drop_count discards evenly over 60 or 50 units
  wire [6:0] drop_count = temporal_drop_control_r[6:0];
  wire [6:0] units_total = std_pal ? UNITS_PAL : UNITS_NTSC;
  wire unit_end = vid_in.field_end && (temporal_drop_control_r[BIT_DEC_UNIT] || field_even_r);
  wire [7:0] acc_sum = {1'b0, acc_r} + {1'b0, drop_count};
  wire acc_wrap = (acc_sum >= {1'b0, units_total});
  wire [6:0] acc_nxt = (drop_count == 7'd0) ? 7'd0 :
                       !unit_end ? acc_r :
                       acc_wrap ? 7'(acc_sum - {1'b0, units_total}) : acc_sum[6:0];
  wire drop_nxt = (drop_count == 7'd0) ? 1'b0 : unit_end ? acc_wrap : drop_r;

  wire [7:0] rdata_nxt = (reg_addr_in == OFS_DEVICE_CONDITION) ? status_rd :
                         (reg_addr_in == OFS_INPUT_SOURCE_FORMAT) ? format_r :
                         (reg_addr_in == OFS_TEMPORAL_DROP_CONTROL) ? temporal_drop_control_r :
                         (reg_addr_in == OFS_WINDOW_UPPER_BITS) ? window_upper_bits_r :
                         (reg_addr_in == OFS_VERTICAL_DELAY_LOW) ? vdly_lo_r : 8'h00;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      format_r <= RST_INPUT_SOURCE_FORMAT;
      temporal_drop_control_r <= RST_TEMPORAL_DROP_CONTROL;
      window_upper_bits_r <= RST_WINDOW_UPPER_BITS;
      vdly_lo_r <= RST_VERTICAL_DELAY_LOW;
    end else begin
      if (wr_format) begin
        format_r <= reg_wdata_in & ~(8'h01 << BIT_RSVD);
      end
      if (wr_temporal_drop_control) begin
        temporal_drop_control_r <= reg_wdata_in;
      end
      if (wr_window_upper_bits) begin
        window_upper_bits_r <= reg_wdata_in;
      end
      if (wr_vdly) begin
        vdly_lo_r <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      present_r <= 1'b0;
      hlock_r <= 1'b0;
      field_even_r <= 1'b0;
      lines_pal_r <= 1'b0;
      luma_ovf_r <= 1'b0;
      chroma_ovf_r <= 1'b0;
      above_cnt_r <= 5'd0;
      match_cnt_r <= 6'd0;
      miss_cnt_r <= 6'd0;
      std_cnt_r <= 6'd0;
      vertical_reset_out_b_d_r <= 1'b1;
    end else begin
      present_r <= present_set ? 1'b1 : present_clr ? 1'b0 : present_r;
      hlock_r <= hlock_nxt;
      field_even_r <= field_even_nxt;
      lines_pal_r <= std_flip ? ~lines_pal_r : lines_pal_r;
      std_cnt_r <= std_flip ? 6'd0 : std_cnt_nxt;
      luma_ovf_r <= luma_ovf_nxt;
      chroma_ovf_r <= chroma_ovf_nxt;
      above_cnt_r <= above_cnt_nxt;
      match_cnt_r <= match_cnt_nxt;
      miss_cnt_r <= miss_cnt_nxt;
      vertical_reset_out_b_d_r <= vertical_reset_out_b_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_r <= 7'd0;
      drop_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
      drop_r <= drop_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign drop_unit_out = drop_r;

  // Configuration outputs straight from the registers
  assign cfg_out.mux_onehot = (mux_sel == MUX_IN0) ? 3'b001 :
                              (mux_sel == MUX_IN1) ? 3'b010 :
                              (mux_sel == MUX_IN2) ? 3'b100 : 3'b000;
  assign cfg_out.crystal_port = crystal_sel;
  assign cfg_out.standard_pal = std_pal;
  assign cfg_out.extend_active = format_r[BIT_EXTEND];
  assign cfg_out.drop_count = drop_count;
  assign cfg_out.decimate_fields = temporal_drop_control_r[BIT_DEC_UNIT];
  assign cfg_out.vertical_delay_count = {window_upper_bits_r[7:6], vdly_lo_r};
  assign cfg_out.vertical_active_msb = window_upper_bits_r[5:4];
  assign cfg_out.horizontal_delay_msb = window_upper_bits_r[3:2];
  assign cfg_out.horizontal_active_msb = window_upper_bits_r[1:0];

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_PRESENT_SET: assert property (vid_in.above_half_sync [*8] ##0 (above_cnt_r == 5'd31)
    |=> present_r) else $error("present flag not set after 31 cycles");
  AST_PRESENT_CLR: assert property (wr_status && !reg_wdata_in[7] && !present_set |=> !present_r)
    else $error("present flag not cleared by zero write");
  AST_HLOCK_WRITE: assert property (wr_status && !vid_in.line_strobe |=> hlock_r == $past(hlock_r))
    else $error("host write moved the lock flag");
  AST_HLOCK_SET: assert property (line_hit && match_cnt_r == 6'd31 |=> hlock_r)
    else $error("lock flag not set on 32nd matching line");
  AST_HLOCK_CLR: assert property (line_miss && miss_cnt_r == 6'd31 |=> !hlock_r)
    else $error("lock flag not cleared on 32nd missing line");
  AST_LUMA_STICKY: assert property (luma_ovf_r && !wr_status |=> luma_ovf_r)
    else $error("luma overflow flag dropped without a write");
  AST_CHROMA_SET_WINS: assert property (vid_in.chroma_ovf && wr_status |=> chroma_ovf_r)
    else $error("chroma overflow lost against a clearing write");
  AST_SLEEP_FORCE: assert property (vid_in.luma_sleep |-> status_rd[1])
    else $error("luma overflow not forced in sleep");
  AST_XTAL_AUTO: assert property (xt_sel == XT_AUTO |-> cfg_out.crystal_port == lines_pal_r)
    else $error("crystal flag differs from line standard in auto mode");
  AST_STD_STABLE: assert property (!std_flip |=> lines_pal_r == $past(lines_pal_r))
    else $error("line standard changed without 32 agreeing fields");
  AST_READBACK: assert property (wr_format ##1 reg_addr_in == OFS_INPUT_SOURCE_FORMAT && !reg_wr_in
    |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'hFB)) else $error("format readback mismatch");
  AST_NO_DROP_ZERO: assert property (drop_count == 7'd0 |=> !drop_unit_out)
    else $error("unit dropped while decimation disabled");

  // Overflow flags
  AST_LUMA_SET_WINS: assert property (vid_in.luma_ovf |=> luma_ovf_r)
    else $error("luma overflow not set");
  AST_CHROMA_STICKY: assert property (chroma_ovf_r && !wr_status |=> chroma_ovf_r)
    else $error("chroma overflow flag dropped without a write");
  AST_LUMA_WRITE_CLR: assert property (wr_status && !vid_in.luma_ovf |=> !luma_ovf_r)
    else $error("luma overflow not cleared by write");
  AST_CHROMA_WRITE_CLR: assert property (wr_status && !vid_in.chroma_ovf |=> !chroma_ovf_r)
    else $error("chroma overflow not cleared by write");
  AST_CHROMA_SLEEP: assert property (vid_in.chroma_sleep |-> status_rd[BIT_CHROMA_OVF])
    else $error("chroma overflow not forced in sleep");

  // Present and lock
  AST_PRESENT_HOLD: assert property (present_r && !present_clr |=> present_r)
    else $error("present flag dropped without a zero write");
  AST_PRESENT_NO_EARLY: assert property (!present_r && !present_set |=> !present_r)
    else $error("present flag set early");
  AST_PRESENT_RISE: assert property ($rose(present_r) |-> $past(above_cnt_r) == PRESENT_CYCLES)
    else $error("present flag rose without a full run");
  AST_HLOCK_IDLE: assert property (!vid_in.line_strobe |=> hlock_r == $past(hlock_r))
    else $error("lock flag moved between lines");
  AST_HLOCK_MISS_UNLOCKED: assert property (line_miss && !hlock_r |=> !hlock_r)
    else $error("lock flag set on a missing line");
  AST_HLOCK_HIT_KEEP: assert property (line_hit && hlock_r |=> hlock_r)
    else $error("lock flag cleared on a matching line");
  AST_HLOCK_RISE: assert property ($rose(hlock_r) |-> $past(line_hit))
    else $error("lock flag rose without a matching line");
  AST_HLOCK_FALL: assert property ($fell(hlock_r) |-> $past(line_miss))
    else $error("lock flag fell without a missing line");

  // Field and line standard
  AST_FIELD_ODD: assert property (vertical_reset_out_start && !horizontal_reset_out_b_in |=> !field_even_r)
    else $error("odd field not reported");
  AST_FIELD_EVEN: assert property (vertical_reset_out_start && horizontal_reset_out_b_in |=> field_even_r)
    else $error("even field not reported");
  AST_FIELD_HOLD: assert property (!vertical_reset_out_start |=> field_even_r == $past(field_even_r))
    else $error("field bit moved inside a field");
  AST_STD_FLIP: assert property (std_flip |=> lines_pal_r != $past(lines_pal_r))
    else $error("line standard did not change");
  AST_LINES_CHANGE: assert property ($changed(lines_pal_r) |-> $past(std_cnt_r) == STD_FIELDS - 6'd1)
    else $error("line standard changed early");

  // Format decode
  AST_XTAL_PORT1: assert property (xt_sel == XT_PORT1 |-> cfg_out.crystal_port)
    else $error("crystal port 1 not selected");
  AST_XTAL_PORT0: assert property (xt_sel == XT_PORT0 |-> !cfg_out.crystal_port)
    else $error("crystal port 0 not selected");
  AST_STD_AUTO: assert property (std_sel == STD_AUTO |-> cfg_out.standard_pal == lines_pal_r)
    else $error("auto standard differs from line standard");
  AST_STD_NTSC: assert property (std_sel == STD_NTSC |-> !cfg_out.standard_pal)
    else $error("fixed NTSC not applied");
  AST_STD_PAL: assert property (std_sel == STD_PAL |-> cfg_out.standard_pal)
    else $error("fixed PAL not applied");
  AST_MUX_ONEHOT: assert property ($onehot0(cfg_out.mux_onehot))
    else $error("more than one input routed");
  AST_MUX_IN0: assert property (mux_sel == MUX_IN0 |-> cfg_out.mux_onehot == 3'b001)
    else $error("input 0 not routed");
  AST_EXTEND: assert property (wr_format |=> cfg_out.extend_active == $past(reg_wdata_in[BIT_EXTEND]))
    else $error("extend bit not applied");

  // Register writes and reads
  AST_FORMAT_WRITE: assert property (wr_format |=> format_r == ($past(reg_wdata_in) & 8'hFB))
    else $error("format write not stored");
  AST_TEMPORAL_DROP_CONTROL_WRITE: assert property (wr_temporal_drop_control |=> temporal_drop_control_r == $past(reg_wdata_in))
    else $error("decimation write not stored");
  AST_WINDOW_UPPER_BITS_WRITE: assert property (wr_window_upper_bits |=> window_upper_bits_r == $past(reg_wdata_in))
    else $error("window write not stored");
  AST_VDLY_WRITE: assert property (wr_vdly |=> vdly_lo_r == $past(reg_wdata_in))
    else $error("vertical delay write not stored");
  AST_VERTICAL_DELAY_COUNT_UPPER: assert property (wr_window_upper_bits |=> cfg_out.vertical_delay_count[9:8] == $past(reg_wdata_in[7:6]))
    else $error("vertical delay upper bits wrong");
  AST_HORIZONTAL_DELAY_COUNT_MSB: assert property (wr_window_upper_bits |=> cfg_out.horizontal_delay_msb == $past(reg_wdata_in[3:2]))
    else $error("horizontal delay upper bits wrong");
  AST_HORIZONTAL_ACTIVE_COUNT_MSB: assert property (wr_window_upper_bits |=> cfg_out.horizontal_active_msb == $past(reg_wdata_in[1:0]))
    else $error("horizontal active upper bits wrong");
  AST_VERTICAL_ACTIVE_COUNT_MSB: assert property (wr_window_upper_bits |=> cfg_out.vertical_active_msb == $past(reg_wdata_in[5:4]))
    else $error("vertical active upper bits wrong");
  AST_RDATA_STATUS: assert property (reg_addr_in == OFS_DEVICE_CONDITION |=> reg_rdata_out == $past(status_rd))
    else $error("status read does not show live state");
  AST_VDLY_READ: assert property (reg_addr_in == OFS_VERTICAL_DELAY_LOW |=> reg_rdata_out == $past(vdly_lo_r))
    else $error("vertical delay read wrong");
  AST_UNMAPPED_READ: assert property (reg_addr_in > OFS_VERTICAL_DELAY_LOW |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  // Decimation
  AST_DROP_HOLD: assert property (!unit_end && drop_count != 7'd0 |=> drop_unit_out == $past(drop_unit_out))
    else $error("drop decision moved inside a unit");
  AST_FRAME_UNIT: assert property (vid_in.field_end && !temporal_drop_control_r[BIT_DEC_UNIT] && !field_even_r && drop_count != 7'd0
    |=> drop_unit_out == $past(drop_unit_out)) else $error("frame mode advanced on an odd field");
  AST_FIELD_UNIT: assert property (vid_in.field_end && temporal_drop_control_r[BIT_DEC_UNIT] && drop_count != 7'd0
    |=> drop_unit_out == $past(acc_wrap)) else $error("field mode drop decision wrong");
  AST_DEC_UNIT: assert property (wr_temporal_drop_control |=> cfg_out.decimate_fields == $past(reg_wdata_in[BIT_DEC_UNIT]))
    else $error("decimate unit not applied");
  AST_DROP_COUNT: assert property (wr_temporal_drop_control |=> cfg_out.drop_count == $past(reg_wdata_in[6:0]))
    else $error("drop count not applied");

  COV_LOCK: cover property (!hlock_r ##1 hlock_r);
  COV_PRESENT: cover property (present_set ##1 present_r);
  COV_STD: cover property (std_flip);
  COV_DROP: cover property (drop_unit_out && cfg_out.decimate_fields);
  COV_FIELD_EVEN: cover property (vertical_reset_out_start && horizontal_reset_out_b_in);
endmodule // vdsr_regs
`default_nettype wire

/* File: verif/vdsr_host_model.sv */
// Host model: register port write and read cycles
`timescale 1ns/1ns
`default_nettype none
module vdsr_host_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  import vdsr_pkg::*;
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  // Callers keep reserved bit 2 of offsets 0 and 1 at zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    // Released data changes so a stale byte is never mistaken for a write
    wdata_out = ~d;
  endtask
  // Two edges: one to register the address, one of margin for flag updates
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    repeat (2) @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
  // Decimation always passes through zero, never above 60 or 50
  task automatic set_drop(input logic [7:0] d);
    wr(OFS_TEMPORAL_DROP_CONTROL, 8'h00);
    wr(OFS_TEMPORAL_DROP_CONTROL, d);
  endtask
endmodule // vdsr_host_model
`default_nettype wire

/* File: verif/tb.sv */
// Testbench: register access, status flags, decimation and configuration decode
`timescale 1ns/1ns
`default_nettype none
module tb;
  import vdsr_pkg::*;
  logic sys_clk_in;
  logic rst_b_in;
  logic [7:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  vdsr_vid_t vid;
  logic hres_b;
  logic vres_b;
  vdsr_cfg_t cfg;
  logic drop_unit;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] d;
  logic [1:0] c;
  logic [2:0] mx [4] = '{3'h0, 3'h4, 3'h1, 3'h2};

  vdsr_regs u_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .vid_in(vid), .horizontal_reset_out_b_in(hres_b),
    .vertical_reset_out_b_in(vres_b), .cfg_out(cfg), .drop_unit_out(drop_unit));
  vdsr_host_model u_host (.clk_in(sys_clk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
    .rdata_in(rdata));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rb(input logic [7:0] a, input logic [7:0] exp, input string what);
    u_host.rd(a, d);
    chk(10'(d), 10'(exp), what);
  endtask
  task automatic bit_chk(input int p, input logic exp);
    u_host.rd(OFS_DEVICE_CONDITION, d);
    chk(10'(d[p]), 10'(exp), "flag");
  endtask
  // Strobe kinds: 0 line, 1 field end, 2 luma overflow, 3 chroma overflow
  task automatic pls(input int k, input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      #1;
      vid.line_strobe = (k == 0);
      vid.field_end = (k == 1);
      vid.luma_ovf = (k == 2);
      vid.chroma_ovf = (k == 3);
      @(posedge sys_clk_in);
      #1;
      vid.line_strobe = 1'b0;
      vid.field_end = 1'b0;
      vid.luma_ovf = 1'b0;
      vid.chroma_ovf = 1'b0;
    end
  endtask
  task automatic above(input int n);
    @(posedge sys_clk_in);
    #1;
    vid.above_half_sync = 1'b1;
    repeat (n) @(posedge sys_clk_in);
    #1;
    vid.above_half_sync = 1'b0;
  endtask
  task automatic vfall(input logic h);
    @(posedge sys_clk_in);
    #1;
    hres_b = h;
    @(posedge sys_clk_in);
    #1;
    vres_b = 1'b0;
    @(posedge sys_clk_in);
    #1;
    vres_b = 1'b1;
    hres_b = 1'b1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Ceiling sits well above the few hundred cycles the sequence needs
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    vid = '0;
    vid.lines_in_field = 10'h106;
    hres_b = 1'b1;
    vres_b = 1'b1;
    rst_b_in = 1'b0;
    repeat (5) @(posedge sys_clk_in);
    #1;
    rst_b_in = 1'b1;
    rb(OFS_DEVICE_CONDITION, RST_DEVICE_CONDITION, "cond");
    rb(OFS_INPUT_SOURCE_FORMAT, RST_INPUT_SOURCE_FORMAT, "fmt");
    rb(OFS_TEMPORAL_DROP_CONTROL, RST_TEMPORAL_DROP_CONTROL, "drop");
    rb(OFS_WINDOW_UPPER_BITS, RST_WINDOW_UPPER_BITS, "win");
    rb(OFS_VERTICAL_DELAY_LOW, RST_VERTICAL_DELAY_LOW, "vdly");
    rb(8'h07, 8'h00, "unmapped");
    chk(10'(cfg.mux_onehot), 10'h001, "mux");
    $display("test reset done");
    for (int i = 1; i < 4; i++) begin
      c = 2'(i);
      d = {c[0], c, c, 1'b0, (i == 3) ? STD_PAL : STD_NTSC};
      u_host.wr(OFS_INPUT_SOURCE_FORMAT, d);
      rb(OFS_INPUT_SOURCE_FORMAT, d, "fmt rw");
      chk(10'(cfg.mux_onehot), 10'(mx[i]), "mux");
      chk(10'(cfg.crystal_port), 10'(i == 2), "xtal");
      chk(10'(cfg.standard_pal), 10'(i == 3), "std");
      chk(10'(cfg.extend_active), 10'(c[0]), "extend");
    end
    u_host.wr(OFS_WINDOW_UPPER_BITS, 8'hE4);
    u_host.wr(OFS_VERTICAL_DELAY_LOW, 8'h5A);
    rb(OFS_WINDOW_UPPER_BITS, 8'hE4, "win rw");
    chk(cfg.vertical_delay_count, 10'h35A, "vertical_delay_count");
    chk(10'(cfg.horizontal_delay_msb), 10'h001, "horizontal_delay_count");
    chk(10'(cfg.horizontal_active_msb), 10'h000, "horizontal_active_count");
    chk(10'(cfg.vertical_active_msb), 10'h002, "vertical_active_count");
    $display("test decode done");
    u_host.wr(OFS_INPUT_SOURCE_FORMAT, RST_INPUT_SOURCE_FORMAT);
    u_host.set_drop(8'h9E);
    chk(10'(cfg.decimate_fields), 10'h001, "unit");
    pls(1, 1);
    chk(10'(drop_unit), 10'h000, "drop 1");
    pls(1, 1);
    chk(10'(drop_unit), 10'h001, "drop 2");
    u_host.wr(OFS_TEMPORAL_DROP_CONTROL, 8'h00);
    @(posedge sys_clk_in);
    #1;
    chk(10'(drop_unit), 10'h000, "drop off");
    u_host.set_drop(8'h1E);
    chk(10'(cfg.decimate_fields), 10'h000, "unit");
    chk(10'(cfg.drop_count), 10'h01E, "rate");
    $display("test decimation done");
    pls(2, 1);
    bit_chk(BIT_LUMA_OVF, 1'b1);
    bit_chk(BIT_LUMA_OVF, 1'b1);
    u_host.wr(OFS_DEVICE_CONDITION, 8'h00);
    bit_chk(BIT_LUMA_OVF, 1'b0);
    pls(3, 1);
    bit_chk(BIT_CHROMA_OVF, 1'b1);
    u_host.wr(OFS_DEVICE_CONDITION, 8'h00);
    bit_chk(BIT_CHROMA_OVF, 1'b0);
    vid.luma_sleep = 1'b1;
    vid.chroma_sleep = 1'b1;
    rb(OFS_DEVICE_CONDITION, 8'h03, "sleep");
    vid.luma_sleep = 1'b0;
    vid.chroma_sleep = 1'b0;
    u_host.wr(OFS_DEVICE_CONDITION, 8'hFB);
    rb(OFS_DEVICE_CONDITION, 8'h00, "write ignored");
    $display("test overflow done");
    above(30);
    bit_chk(BIT_PRESENT, 1'b0);
    above(40);
    bit_chk(BIT_PRESENT, 1'b1);
    u_host.wr(OFS_DEVICE_CONDITION, 8'h00);
    bit_chk(BIT_PRESENT, 1'b0);
    vid.hsync_match = 1'b1;
    pls(0, 31);
    bit_chk(BIT_HLOCK, 1'b0);
    pls(0, 1);
    bit_chk(BIT_HLOCK, 1'b1);
    vid.hsync_match = 1'b0;
    pls(0, 31);
    bit_chk(BIT_HLOCK, 1'b1);
    pls(0, 1);
    bit_chk(BIT_HLOCK, 1'b0);
    vfall(1'b0);
    bit_chk(BIT_FIELD, 1'b0);
    vfall(1'b1);
    bit_chk(BIT_FIELD, 1'b1);
    pls(1, 1);
    chk(10'(drop_unit), 10'h000, "frame 1");
    pls(1, 1);
    chk(10'(drop_unit), 10'h001, "frame 2");
    $display("test live flags done");
    vid.lines_in_field = 10'h138;
    pls(1, 31);
    bit_chk(BIT_LINES, 1'b0);
    pls(1, 1);
    bit_chk(BIT_LINES, 1'b1);
    bit_chk(BIT_XTAL, 1'b1);
    chk(10'(cfg.standard_pal), 10'h001, "auto std");
    u_host.wr(OFS_INPUT_SOURCE_FORMAT, 8'h48);
    bit_chk(BIT_XTAL, 1'b0);
    $display("test line standard done");
    close_out();
  end
endmodule // tb
`default_nettype wire
